/* File: design/acbp_cfg.svh */
`ifndef ACBP_CFG_SVH
`define ACBP_CFG_SVH
// register file geometry
`define ACBP_ADDR_W 6
`define ACBP_DATA_W 8
`define ACBP_NUM_REGS 64
// interrupt condition register and its mask sit at these indices
`define ACBP_ICR_IDX 6'h02
`define ACBP_IRQ_CONDITION_MASK_REG_IDX 6'h03
// bit of the condition register that flags a write parity error
`define ACBP_CPE_BIT 3
// reset values
`define ACBP_IRQ_CONDITION_MASK_REG_RST 8'h00
`define ACBP_REG_RST 8'h00
// synchroniser reset level matches the idle-high pins
`define ACBP_SYNC_IDLE 2'h3
`endif

/* File: design/acbp_pkg.sv */
package acbp_pkg;
	// device port cycle states
	typedef enum logic [1:0] {
		ACBP_DEV_IDLE,
		ACBP_DEV_ACK
	} acbp_dev_state_t;
	// host cycle states
	typedef enum logic [1:0] {
		ACBP_HOST_IDLE,
		ACBP_HOST_WAIT,
		ACBP_HOST_RELEASE
	} acbp_host_state_t;
endpackage : acbp_pkg

/* File: design/acbp_if.sv */
`timescale 1ns/10ps
`include "acbp_cfg.svh"
// shared control bus; open-drain lines are low when the device enables
interface acbp_if;
	logic ce_n;
	logic rd_wr;
	logic [`ACBP_ADDR_W-1:0] mgmt_addr;
	logic [`ACBP_DATA_W-1:0] host_data_o;
	logic host_data_oe;
	logic host_par_o;
	logic [`ACBP_DATA_W-1:0] dev_data_o;
	logic dev_data_oe;
	logic dev_par_o;
	logic ack_oe;
	logic int_oe;
	logic [`ACBP_DATA_W-1:0] mgmt_data;
	logic mgmt_data_parity;
	logic ack_n;
	logic int_n;
	// resolved wire levels; bus keeper idles high
	assign mgmt_data = dev_data_oe ? dev_data_o :
		(host_data_oe ? host_data_o : {`ACBP_DATA_W{1'b1}});
	assign mgmt_data_parity = dev_data_oe ? dev_par_o :
		(host_data_oe ? host_par_o : 1'b1);
	assign ack_n = ~ack_oe;
	assign int_n = ~int_oe;
	modport device (
		input ce_n,
		input rd_wr,
		input mgmt_addr,
		input mgmt_data,
		input mgmt_data_parity,
		output dev_data_o,
		output dev_data_oe,
		output dev_par_o,
		output ack_oe,
		output int_oe
	);
	modport host (
		output ce_n,
		output rd_wr,
		output mgmt_addr,
		output host_data_o,
		output host_data_oe,
		output host_par_o,
		input mgmt_data,
		input mgmt_data_parity,
		input ack_n,
		input int_n
	);
endinterface : acbp_if

/* File: design/acbp_device.sv */
`timescale 1ns/10ps
`include "acbp_cfg.svh"
module acbp_device #(
	parameter int ADDR_W = `ACBP_ADDR_W,
	parameter int DATA_W = `ACBP_DATA_W
)(
	input wire logic ref_clk,
	input wire logic reset,
	acbp_if.device bus,
	input wire logic [DATA_W-1:0] irq_event,
	output logic [DATA_W-1:0] reg_view_data,
	output logic irq_pending
);
	localparam int NREGS = 1 << ADDR_W;
	acbp_pkg::acbp_dev_state_t state_reg;
	logic [1:0] ce_sync_reg;
	logic [1:0] rw_sync_reg;
	logic [ADDR_W-1:0] addr_sync1_reg;
	logic [ADDR_W-1:0] addr_sync2_reg;
	logic [DATA_W-1:0] data_sync1_reg;
	logic [DATA_W-1:0] data_sync2_reg;
	logic par_sync1_reg;
	logic par_sync2_reg;
	logic [DATA_W-1:0] regs_reg [NREGS];
	logic [DATA_W-1:0] icr_reg;
	logic [DATA_W-1:0] irq_condition_mask_reg_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic rd_par_reg;
	logic rd_oe_reg;
	logic ack_reg;
	logic int_reg;
	logic start;
	logic is_read;
	logic par_ok;
	logic wr_ok;
	logic wr_bad;
	logic [DATA_W-1:0] rd_value;
	logic [DATA_W-1:0] icr_next;

	// two-flop synchronisers on every pin input
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ce_sync_reg <= `ACBP_SYNC_IDLE;
			rw_sync_reg <= `ACBP_SYNC_IDLE;
			addr_sync1_reg <= '0;
			addr_sync2_reg <= '0;
			data_sync1_reg <= '0;
			data_sync2_reg <= '0;
			par_sync1_reg <= 1'b0;
			par_sync2_reg <= 1'b0;
		end
		else
		begin
			ce_sync_reg <= {ce_sync_reg[0], bus.ce_n};
			rw_sync_reg <= {rw_sync_reg[0], bus.rd_wr};
			addr_sync1_reg <= bus.mgmt_addr;
			addr_sync2_reg <= addr_sync1_reg;
			data_sync1_reg <= bus.mgmt_data;
			data_sync2_reg <= data_sync1_reg;
			par_sync1_reg <= bus.mgmt_data_parity;
			par_sync2_reg <= par_sync1_reg;
		end
	end

	// start a cycle only in idle with enable low
	assign start = (state_reg == acbp_pkg::ACBP_DEV_IDLE) && !ce_sync_reg[1];
	assign is_read = rw_sync_reg[1]; // high reads, low writes
	// odd parity: nine bits together carry an odd count of ones
	assign par_ok = ^{data_sync2_reg, par_sync2_reg};
	assign wr_ok = start && !is_read && par_ok;
	assign wr_bad = start && !is_read && !par_ok;

	// read mux; the two interrupt registers live outside the array
	always_comb
	begin
		if (addr_sync2_reg == `ACBP_ICR_IDX)
			rd_value = icr_reg;
		else if (addr_sync2_reg == `ACBP_IRQ_CONDITION_MASK_REG_IDX)
			rd_value = irq_condition_mask_reg_reg;
		else
			rd_value = regs_reg[addr_sync2_reg];
	end

	// handshake: acknowledge held until enable goes high
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			state_reg <= acbp_pkg::ACBP_DEV_IDLE;
		else
			case (state_reg)
				acbp_pkg::ACBP_DEV_IDLE:
					if (start)
						state_reg <= acbp_pkg::ACBP_DEV_ACK;
				acbp_pkg::ACBP_DEV_ACK:
					if (ce_sync_reg[1])
						state_reg <= acbp_pkg::ACBP_DEV_IDLE;
				default:
					state_reg <= acbp_pkg::ACBP_DEV_IDLE;
			endcase
	end

	// pin drivers; data released outside a read acknowledge
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ack_reg <= 1'b0;
			rd_oe_reg <= 1'b0;
			rd_data_reg <= '0;
			rd_par_reg <= 1'b0;
		end
		else if (start)
		begin
			ack_reg <= 1'b1;
			rd_oe_reg <= is_read;
			// writes leave the last read data on view
			if (is_read)
			begin
				rd_data_reg <= rd_value;
				rd_par_reg <= ~^rd_value; // odd parity out
			end
		end
		else if (state_reg == acbp_pkg::ACBP_DEV_ACK && ce_sync_reg[1])
		begin
			ack_reg <= 1'b0;
			rd_oe_reg <= 1'b0;
		end
	end

	// register array; a write with bad parity leaves it untouched
	generate
		for (genvar i = 0; i < NREGS; i++)
		begin : g_regs
			always_ff @(posedge ref_clk)
			begin
				if (reset)
					regs_reg[i] <= `ACBP_REG_RST;
				else if (wr_ok && addr_sync2_reg == ADDR_W'(i))
					regs_reg[i] <= data_sync2_reg;
			end
		end
	endgenerate

	// mask register, written like any other register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			irq_condition_mask_reg_reg <= `ACBP_IRQ_CONDITION_MASK_REG_RST;
		else if (wr_ok && addr_sync2_reg == `ACBP_IRQ_CONDITION_MASK_REG_IDX)
			irq_condition_mask_reg_reg <= data_sync2_reg;
	end

	// conditions are sticky; writing ones clears, a new event wins
	always_comb
	begin
		icr_next = icr_reg;
		if (wr_ok && addr_sync2_reg == `ACBP_ICR_IDX)
			icr_next = icr_reg & ~data_sync2_reg;
		icr_next = icr_next | irq_event;
		if (wr_bad)
			icr_next[`ACBP_CPE_BIT] = 1'b1;
	end

	// condition register state; next value built above
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			icr_reg <= '0;
		else
			icr_reg <= icr_next;
	end

	// interrupt pin, gated per bit by the mask
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			int_reg <= 1'b0;
		else
			int_reg <= |(icr_next & ~irq_condition_mask_reg_reg);
	end

	assign bus.ack_oe = ack_reg;
	assign bus.dev_data_oe = rd_oe_reg;
	assign bus.dev_data_o = rd_data_reg;
	assign bus.dev_par_o = rd_par_reg;
	assign bus.int_oe = int_reg;
	assign irq_pending = int_reg;
	assign reg_view_data = rd_data_reg;
endmodule : acbp_device

/* File: design/acbp_host.sv */
`timescale 1ns/10ps
`include "acbp_cfg.svh"
// host end: one register access per request, fully interlocked
module acbp_host #(
	parameter int ADDR_W = `ACBP_ADDR_W,
	parameter int DATA_W = `ACBP_DATA_W
)(
	input wire logic ref_clk,
	input wire logic reset,
	acbp_if.host bus,
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic req_bad_parity,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic rsp_parity_err,
	output logic irq_seen
);
	acbp_pkg::acbp_host_state_t state_reg;
	logic [1:0] ack_sync_reg;
	logic [1:0] int_sync_reg;
	logic [DATA_W-1:0] d_sync1_reg;
	logic [DATA_W-1:0] d_sync2_reg;
	logic p_sync1_reg;
	logic p_sync2_reg;
	logic ce_n_reg;
	logic rd_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic par_reg;
	logic oe_reg;
	logic ready_reg;
	logic rsp_valid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic perr_reg;

	// pin inputs through two flops
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ack_sync_reg <= `ACBP_SYNC_IDLE;
			int_sync_reg <= `ACBP_SYNC_IDLE;
			d_sync1_reg <= '0;
			d_sync2_reg <= '0;
			p_sync1_reg <= 1'b0;
			p_sync2_reg <= 1'b0;
		end
		else
		begin
			ack_sync_reg <= {ack_sync_reg[0], bus.ack_n};
			int_sync_reg <= {int_sync_reg[0], bus.int_n};
			d_sync1_reg <= bus.mgmt_data;
			d_sync2_reg <= d_sync1_reg;
			p_sync1_reg <= bus.mgmt_data_parity;
			p_sync2_reg <= p_sync1_reg;
		end
	end

	// cycle sequencer; all fields set up on the same edge that enable falls
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg <= acbp_pkg::ACBP_HOST_IDLE;
			ce_n_reg <= 1'b1;
			rd_reg <= 1'b1;
			addr_reg <= '0;
			wdata_reg <= '0;
			par_reg <= 1'b0;
			oe_reg <= 1'b0;
			ready_reg <= 1'b1;
			rsp_valid_reg <= 1'b0;
			rdata_reg <= '0;
			perr_reg <= 1'b0;
		end
		else
		begin
			rsp_valid_reg <= 1'b0;
			case (state_reg)
				acbp_pkg::ACBP_HOST_IDLE:
					if (req_valid && ready_reg)
					begin
						rd_reg <= req_read;
						addr_reg <= req_addr;
						wdata_reg <= req_wdata;
						// odd parity, optionally spoiled for
						par_reg <= (~^req_wdata) ^ req_bad_parity;
						oe_reg <= !req_read;
						ce_n_reg <= 1'b0;
						ready_reg <= 1'b0;
						state_reg <= acbp_pkg::ACBP_HOST_WAIT;
					end
				acbp_pkg::ACBP_HOST_WAIT:
					if (!ack_sync_reg[1])
					begin
						// data held to here
						rdata_reg <= d_sync2_reg;
						perr_reg <= rd_reg && !(^{d_sync2_reg, p_sync2_reg});
						ce_n_reg <= 1'b1;
						oe_reg <= 1'b0;
						state_reg <= acbp_pkg::ACBP_HOST_RELEASE;
					end
				acbp_pkg::ACBP_HOST_RELEASE:
					if (ack_sync_reg[1])
					begin
						rsp_valid_reg <= 1'b1;
						ready_reg <= 1'b1;
						state_reg <= acbp_pkg::ACBP_HOST_IDLE;
					end
				default:
					state_reg <= acbp_pkg::ACBP_HOST_IDLE;
			endcase
		end
	end

	// interrupt seen; user then reads the condition register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			irq_seen <= 1'b0;
		else
			irq_seen <= !int_sync_reg[1];
	end

	assign bus.ce_n = ce_n_reg;
	assign bus.rd_wr = rd_reg;
	assign bus.mgmt_addr = addr_reg;
	assign bus.host_data_o = wdata_reg;
	assign bus.host_par_o = par_reg;
	assign bus.host_data_oe = oe_reg;
	assign req_ready = ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_rdata = rdata_reg;
	assign rsp_parity_err = perr_reg;
endmodule : acbp_host

/* File: bench/acbp_checker.sv */
`timescale 1ns/10ps
`include "acbp_cfg.svh"
// watches the shared bus between the two ends
module acbp_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce_n,
	input wire logic rd_wr,
	input wire logic [`ACBP_DATA_W-1:0] mgmt_data,
	input wire logic mgmt_data_parity,
	input wire logic dev_data_oe,
	input wire logic ack_oe,
	input wire logic int_n
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	a_ack_not_early: assert property ($fell(ce_n)
		|-> !ack_oe ##1 !ack_oe)
		else $error("ack before enable synchronised");
	a_ack_cause: assert property ($rose(ack_oe)
		|-> !ce_n && !$past(ce_n, 2))
		else $error("ack without enable");
	a_ack_within: assert property ($fell(ce_n) |-> ##[1:5] ack_oe)
		else $error("ack missing");
	a_ack_hold: assert property (ack_oe && !ce_n |=> ack_oe)
		else $error("ack dropped while enabled");
	a_ack_drop: assert property ($rose(ce_n) |-> ##[1:5] !ack_oe)
		else $error("ack not released");
	a_read_drive: assert property (ack_oe && rd_wr && !ce_n
		|-> dev_data_oe)
		else $error("read data not driven");
	a_write_float: assert property (!ce_n && !rd_wr |-> !dev_data_oe)
		else $error("device drives during write");
	a_oe_with_ack: assert property (dev_data_oe
		|-> ack_oe || $past(ack_oe))
		else $error("device drives outside ack");
	a_odd_par: assert property (dev_data_oe
		|-> ^{mgmt_data_parity, mgmt_data})
		else $error("read parity not odd");
	a_read_stable: assert property (ack_oe && $past(ack_oe)
		&& dev_data_oe && $past(dev_data_oe) |-> $stable(mgmt_data))
		else $error("read data moved during ack");
	c_read: cover property ($rose(ack_oe) && rd_wr);
	c_write: cover property ($rose(ack_oe) && !rd_wr);
	c_int: cover property ($fell(int_n));
endmodule : acbp_checker

/* File: bench/async_control_bus_port_bench.sv */
`timescale 1ns/10ps
module async_control_bus_port_bench;
	logic ref_clk, reset, req_valid, req_read, req_bad_parity;
	logic req_ready, rsp_valid, rsp_parity_err, irq_seen, irq_pending;
	logic [5:0] req_addr;
	logic [7:0] req_wdata, rsp_rdata, irq_event, reg_view_data;
	int fails, checks_done;
	acbp_if acbp_if_i ();
	acbp_device acbp_device_i (.ref_clk(ref_clk), .reset(reset),
		.bus(acbp_if_i), .irq_event(irq_event),
		.reg_view_data(reg_view_data), .irq_pending(irq_pending));
	acbp_host acbp_host_i (.ref_clk(ref_clk), .reset(reset),
		.bus(acbp_if_i), .req_valid(req_valid), .req_read(req_read),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.req_bad_parity(req_bad_parity), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_parity_err(rsp_parity_err), .irq_seen(irq_seen));
	acbp_checker acbp_checker_i (.ref_clk(ref_clk), .reset(reset),
		.ce_n(acbp_if_i.ce_n), .rd_wr(acbp_if_i.rd_wr),
		.mgmt_data(acbp_if_i.mgmt_data),
		.mgmt_data_parity(acbp_if_i.mgmt_data_parity),
		.dev_data_oe(acbp_if_i.dev_data_oe), .ack_oe(acbp_if_i.ack_oe),
		.int_n(acbp_if_i.int_n));
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	task conclude;
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one host request; the response pulse is caught at a falling edge
	task xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
		input logic bp, output logic [7:0] q);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_read = rd;
		req_addr = a;
		req_wdata = d;
		req_bad_parity = bp;
		@(negedge ref_clk);
		req_valid = 1'b0;
		chk("busy", {7'h00, req_ready}, 8'h00);
		while (rsp_valid !== 1'b1)
		begin
			@(negedge ref_clk);
			n++;
			if (n > 40)
			begin
				fails++;
				conclude();
			end
		end
		q = rsp_rdata;
		chk("ready", {7'h00, req_ready}, 8'h01);
		if (rd)
			chk("read parity", {7'h00, rsp_parity_err}, 8'h00);
	endtask : xfer
	// distinct addresses across the range keep their own data
	task t_regs;
		logic [5:0] a [4];
		logic [7:0] q;
		a = '{6'h00, 6'h3F, 6'h15, 6'h2A};
		foreach (a[i])
			xfer(1'b0, a[i], {2'h0, a[i]} ^ 8'hA4, 1'b0, q);
		foreach (a[i])
		begin
			xfer(1'b1, a[i], 8'h00, 1'b0, q);
			chk("rdata", q, {2'h0, a[i]} ^ 8'hA4);
			chk("view", reg_view_data, {2'h0, a[i]} ^ 8'hA4);
		end
	endtask : t_regs
	// a write with wrong parity is dropped and flagged
	task t_parity;
		logic [7:0] q;
		xfer(1'b0, 6'h05, 8'h5A, 1'b0, q);
		xfer(1'b0, 6'h05, 8'hFF, 1'b1, q);
		xfer(1'b1, 6'h05, 8'h00, 1'b0, q);
		chk("kept", q, 8'h5A);
		xfer(1'b1, 6'h02, 8'h00, 1'b0, q);
		chk("cond", q, 8'h08);
		chk("pending", {7'h00, irq_pending}, 8'h01);
		chk("seen", {7'h00, irq_seen}, 8'h01);
		xfer(1'b0, 6'h02, 8'hFF, 1'b0, q);
		repeat (5) @(negedge ref_clk);
		chk("cleared", {7'h00, irq_pending}, 8'h00);
	endtask : t_parity
	// a masked condition is recorded but stays off the pin
	task t_mask;
		logic [7:0] q;
		xfer(1'b0, 6'h03, 8'h01, 1'b0, q);
		irq_event = 8'h01;
		@(negedge ref_clk);
		irq_event = 8'h00;
		repeat (5) @(negedge ref_clk);
		chk("masked", {7'h00, irq_pending}, 8'h00);
		xfer(1'b1, 6'h02, 8'h00, 1'b0, q);
		chk("cond0", q, 8'h01);
		xfer(1'b1, 6'h03, 8'h00, 1'b0, q);
		chk("mask", q, 8'h01);
		irq_event = 8'h02;
		@(negedge ref_clk);
		irq_event = 8'h00;
		repeat (5) @(negedge ref_clk);
		chk("unmasked", {7'h00, irq_pending}, 8'h01);
		chk("int pin", {7'h00, acbp_if_i.int_n}, 8'h00);
		xfer(1'b0, 6'h02, 8'hFF, 1'b0, q);
		xfer(1'b1, 6'h02, 8'h00, 1'b0, q);
		chk("cond clr", q, 8'h00);
	endtask : t_mask
	// a reset in mid-run drops the pin, the mask and the array
	task t_reset;
		logic [7:0] q;
		irq_event = 8'h10;
		@(negedge ref_clk);
		irq_event = 8'h00;
		repeat (4) @(negedge ref_clk);
		chk("pre reset", {7'h00, irq_pending}, 8'h01);
		reset = 1'b1;
		repeat (3) @(negedge ref_clk);
		reset = 1'b0;
		chk("rst ready", {7'h00, req_ready}, 8'h01);
		chk("rst pin", {7'h00, acbp_if_i.int_n}, 8'h01);
		xfer(1'b1, 6'h03, 8'h00, 1'b0, q);
		chk("rst mask", q, 8'h00);
		xfer(1'b1, 6'h05, 8'h00, 1'b0, q);
		chk("rst reg", q, 8'h00);
	endtask : t_reset
	// inputs change at falling edges only
	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_addr = 6'h00;
		req_wdata = 8'h00;
		req_bad_parity = 1'b0;
		irq_event = 8'h00;
		fails = 0;
		checks_done = 0;
		repeat (3) @(negedge ref_clk);
		reset = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk("idle ack", {7'h00, acbp_if_i.ack_n}, 8'h01);
		chk("idle oe", {7'h00, acbp_if_i.dev_data_oe}, 8'h00);
		t_regs();
		t_parity();
		t_mask();
		t_reset();
		conclude();
	end
endmodule : async_control_bus_port_bench
